// *** rtl/lsd_decode.sv ***
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps
// Contract
// - g picks data or program memory space
// - d picks load or store
// - u picks pre-modify or post-modify
// - compute-less form: conditional move, 6-bit immediate
// - condition 11111 means unconditional
// - compute-less form issues no compute
// - address is index+imm pre, index post
// - post-modify writes index plus immediate back
// - condition gates access and index update
// - dual mode runs both elements together
// - secondary address adds k of 1/2/4
// - secondary uses complementary data register
// - condition evaluated per element independently
// - broadcast bits force k zero on reads
// - stores byte/short only, loads also sign options
// - lxw 111 normal, w=0 selects byte/short
// - sub-word loads zero-extend, stores write low bits
// - sub-word outside byte space raises fault
// - sign-extend options sign-extend, loads only
module lsd_decode (
    // Clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 reset_n_in,
    // Register port
    input  wire logic [3:0]           reg_addr_in,
    input  wire logic [31:0]          reg_wdata_in,
    input  wire logic                 reg_write_in,
    input  wire logic                 reg_read_in,
    output logic      [31:0]          reg_rdata_out,
    // Instruction fields
    input  wire logic                 instr_valid_in,
    input  wire logic                 form_visa_in,
    input  wire logic [4:0]           cond_in,
    input  wire logic                 g_in,
    input  wire logic                 d_in,
    input  wire logic                 u_in,
    input  wire logic [2:0]           index_num_in,
    input  wire logic [3:0]           dreg_num_in,
    input  wire logic [5:0]           imm_in,
    input  wire logic                 l_in,
    input  wire logic                 x_in,
    input  wire logic                 w_in,
    // Condition evaluator
    input  wire logic                 cond_true_x_in,
    input  wire logic                 cond_true_y_in,
    // Index register file
    output logic      [3:0]           index_sel_out,
    input  wire logic [31:0]          index_value_in,
    input  wire logic                 byte_space_in,
    output logic                      index_we_out,
    output logic      [3:0]           index_wsel_out,
    output logic      [31:0]          index_wdata_out,
    // Register file, store side
    output logic      [3:0]           rf_read_sel_out,
    input  wire logic [31:0]          rf_read_x_in,
    input  wire logic [31:0]          rf_read_y_in,
    // Register file, load side
    output logic                      rf_write_x_en_out,
    output logic                      rf_write_y_en_out,
    output logic      [3:0]           rf_write_sel_out,
    output logic      [31:0]          rf_write_x_data_out,
    output logic      [31:0]          rf_write_y_data_out,
    // Memory port
    output logic                      mem_x_req_out,
    output logic                      mem_y_req_out,
    output logic      [31:0]          mem_x_addr_out,
    output logic      [31:0]          mem_y_addr_out,
    output logic      [31:0]          mem_x_wdata_out,
    output logic      [31:0]          mem_y_wdata_out,
    output logic                      mem_write_out,
    output logic                      mem_pm_out,
    output lsd_pkg::lsd_size_e        mem_size_out,
    input  wire logic [31:0]          mem_x_rdata_in,
    input  wire logic [31:0]          mem_y_rdata_in,
    // Compute and faults
    output logic                      compute_en_out,
    output logic                      illegal_space_out,
    output logic                      illegal_op_out
);
    function automatic logic [31:0] k_of(input lsd_pkg::lsd_size_e s);
        case (s)
            lsd_pkg::LSD_SIZE_BYTE:  k_of = lsd_pkg::K_BYTE;
            lsd_pkg::LSD_SIZE_SHORT: k_of = lsd_pkg::K_SHORT;
            default:                 k_of = lsd_pkg::K_NORMAL;
        endcase
    endfunction

    function automatic logic [31:0] low_bits(input logic [31:0] v,
                                             input lsd_pkg::lsd_size_e s);
        case (s)
            lsd_pkg::LSD_SIZE_BYTE:  low_bits = {24'h000000, v[7:0]};
            lsd_pkg::LSD_SIZE_SHORT: low_bits = {16'h0000, v[15:0]};
            default:                 low_bits = v;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Decode
    lsd_pkg::lsd_size_e size;
    logic               sign;
    logic               legal;
    logic               uncond;
    logic               ok_x;
    logic               ok_y;
    logic               bcast;
    logic               fault_space;
    logic               go;
    logic [31:0]        imm_ext;
    logic [31:0]        k;
    logic [31:0]        base_x;
    logic [2:0]         ctrl_q;
    logic [2:0]         ctrl_d;

    lsd_size_decode u_size (
        .form_visa_in (form_visa_in),
        .store_in     (d_in),
        .l_in         (l_in),
        .x_in         (x_in),
        .w_in         (w_in),
        .size_out     (size),
        .sign_out     (sign),
        .legal_out    (legal)
    );

    assign index_sel_out   = {g_in, index_num_in};
    assign rf_read_sel_out = dreg_num_in;

    always_comb begin
        uncond  = cond_in == lsd_pkg::COND_ALWAYS;
        ok_x    = uncond | cond_true_x_in;
        ok_y    = ctrl_q[lsd_pkg::CTRL_SIMD_BIT]
                  & (uncond | cond_true_y_in);
        imm_ext = {{26{imm_in[5]}}, imm_in};
        bcast   = !d_in && ((index_sel_out == lsd_pkg::BCAST_IDX_DAG1
                             && ctrl_q[lsd_pkg::CTRL_BC1_BIT])
                         || (index_sel_out == lsd_pkg::BCAST_IDX_DAG2
                             && ctrl_q[lsd_pkg::CTRL_BC2_BIT]));
        k       = bcast ? lsd_pkg::K_BCAST : k_of(size);
        base_x  = u_in ? index_value_in
                       : index_value_in + imm_ext;
        // Address space is checked before the condition is looked at
        fault_space = instr_valid_in && legal
                      && size != lsd_pkg::LSD_SIZE_WORD
                      && !byte_space_in;
        go      = instr_valid_in && legal && !fault_space;
    end

    ////////////////////////////////////////////////////////////////////
    // Issue stage
    logic               req_x_q, req_x_d;
    logic               req_y_q, req_y_d;
    logic [31:0]        addr_x_q, addr_x_d;
    logic [31:0]        addr_y_q, addr_y_d;
    logic [31:0]        wd_x_q, wd_x_d;
    logic [31:0]        wd_y_q, wd_y_d;
    logic               we_q, we_d;
    logic               pm_q, pm_d;
    lsd_pkg::lsd_size_e size_q, size_d;
    logic               sign_q, sign_d;
    logic [3:0]         dst_q, dst_d;
    logic               iwe_q, iwe_d;
    logic [3:0]         isel_q, isel_d;
    logic [31:0]        iwd_q, iwd_d;
    logic               cmp_q, cmp_d;
    logic               fsp_q, fsp_d;
    logic               fop_q, fop_d;

    always_comb begin
        req_x_d  = go && ok_x;
        req_y_d  = go && ok_y;
        addr_x_d = base_x;
        addr_y_d = base_x + k;
        we_d     = d_in;
        pm_d     = g_in;
        size_d   = size;
        sign_d   = sign;
        dst_d    = dreg_num_in;
        wd_x_d   = low_bits(rf_read_x_in, size);
        wd_y_d   = low_bits(rf_read_y_in, size);
        iwe_d    = go && u_in && (ok_x || ok_y);
        isel_d   = index_sel_out;
        iwd_d    = index_value_in + imm_ext;
        // Only the compute-capable form may start a compute
        cmp_d    = go && !form_visa_in && (ok_x || ok_y);
        fsp_d    = fault_space;
        fop_d    = instr_valid_in && !legal;
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            req_x_q  <= 1'b0;
            req_y_q  <= 1'b0;
            addr_x_q <= 32'h0;
            addr_y_q <= 32'h0;
            wd_x_q   <= 32'h0;
            wd_y_q   <= 32'h0;
            we_q     <= 1'b0;
            pm_q     <= 1'b0;
            size_q   <= lsd_pkg::LSD_SIZE_WORD;
            sign_q   <= 1'b0;
            dst_q    <= 4'h0;
            iwe_q    <= 1'b0;
            isel_q   <= 4'h0;
            iwd_q    <= 32'h0;
            cmp_q    <= 1'b0;
            fsp_q    <= 1'b0;
            fop_q    <= 1'b0;
        end else begin
            req_x_q  <= req_x_d;
            req_y_q  <= req_y_d;
            addr_x_q <= addr_x_d;
            addr_y_q <= addr_y_d;
            wd_x_q   <= wd_x_d;
            wd_y_q   <= wd_y_d;
            we_q     <= we_d;
            pm_q     <= pm_d;
            size_q   <= size_d;
            sign_q   <= sign_d;
            dst_q    <= dst_d;
            iwe_q    <= iwe_d;
            isel_q   <= isel_d;
            iwd_q    <= iwd_d;
            cmp_q    <= cmp_d;
            fsp_q    <= fsp_d;
            fop_q    <= fop_d;
        end
    end

    assign mem_x_req_out     = req_x_q;
    assign mem_y_req_out     = req_y_q;
    assign mem_x_addr_out    = addr_x_q;
    assign mem_y_addr_out    = addr_y_q;
    assign mem_x_wdata_out   = wd_x_q;
    assign mem_y_wdata_out   = wd_y_q;
    assign mem_write_out     = we_q;
    assign mem_pm_out        = pm_q;
    assign mem_size_out      = size_q;
    assign index_we_out      = iwe_q;
    assign index_wsel_out    = isel_q;
    assign index_wdata_out   = iwd_q;
    assign compute_en_out    = cmp_q;
    assign illegal_space_out = fsp_q;
    assign illegal_op_out    = fop_q;

    ////////////////////////////////////////////////////////////////////
    // Load return: memory data stand the cycle after the request
    logic               pend_x_q, pend_x_d;
    logic               pend_y_q, pend_y_d;
    lsd_pkg::lsd_size_e psize_q, psize_d;
    logic               psign_q, psign_d;
    logic [3:0]         pdst_q, pdst_d;
    logic               rwx_q, rwx_d;
    logic               rwy_q, rwy_d;
    logic [3:0]         rsel_q, rsel_d;
    logic [31:0]        rdx_q, rdx_d;
    logic [31:0]        rdy_q, rdy_d;
    logic [31:0]        raw [2];
    logic [31:0]        ext [2];

    assign raw[0] = mem_x_rdata_in;
    assign raw[1] = mem_y_rdata_in;

    genvar lane;
    generate
        for (lane = 0; lane < 2; lane++) begin : g_lane
            lsd_load_extend u_ext (
                .raw_in   (raw[lane]),
                .size_in  (psize_q),
                .sign_in  (psign_q),
                .data_out (ext[lane])
            );
        end
    endgenerate

    always_comb begin
        pend_x_d = req_x_q && !we_q;
        pend_y_d = req_y_q && !we_q;
        psize_d  = size_q;
        psign_d  = sign_q;
        pdst_d   = dst_q;
        rwx_d    = pend_x_q;
        rwy_d    = pend_y_q;
        rsel_d   = pdst_q;
        rdx_d    = ext[0];
        rdy_d    = ext[1];
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pend_x_q <= 1'b0;
            pend_y_q <= 1'b0;
            psize_q  <= lsd_pkg::LSD_SIZE_WORD;
            psign_q  <= 1'b0;
            pdst_q   <= 4'h0;
            rwx_q    <= 1'b0;
            rwy_q    <= 1'b0;
            rsel_q   <= 4'h0;
            rdx_q    <= 32'h0;
            rdy_q    <= 32'h0;
        end else begin
            pend_x_q <= pend_x_d;
            pend_y_q <= pend_y_d;
            psize_q  <= psize_d;
            psign_q  <= psign_d;
            pdst_q   <= pdst_d;
            rwx_q    <= rwx_d;
            rwy_q    <= rwy_d;
            rsel_q   <= rsel_d;
            rdx_q    <= rdx_d;
            rdy_q    <= rdy_d;
        end
    end

    assign rf_write_x_en_out   = rwx_q;
    assign rf_write_y_en_out   = rwy_q;
    assign rf_write_sel_out    = rsel_q;
    assign rf_write_x_data_out = rdx_q;
    assign rf_write_y_data_out = rdy_q;

    ////////////////////////////////////////////////////////////////////
    // Register port
    logic [7:0]  nsp_q, nsp_d;
    logic [7:0]  nop_q, nop_d;
    logic [31:0] rd_q, rd_d;

    always_comb begin
        ctrl_d = ctrl_q;
        if (reg_write_in && reg_addr_in == lsd_pkg::CTRL_OFFSET) begin
            ctrl_d = reg_wdata_in[2:0];
        end
        // Fault counters wrap; software reads differences
        nsp_d = nsp_q + {7'h00, fault_space};
        nop_d = nop_q + {7'h00, instr_valid_in && !legal};
        rd_d  = 32'h0;
        if (reg_read_in && reg_addr_in == lsd_pkg::CTRL_OFFSET) begin
            rd_d = {29'h0, ctrl_q};
        end else if (reg_read_in
                     && reg_addr_in == lsd_pkg::STATUS_OFFSET) begin
            rd_d = {15'h0, pend_x_q | pend_y_q, nop_q, nsp_q};
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ctrl_q <= lsd_pkg::CTRL_RESET;
            nsp_q  <= lsd_pkg::COUNT_RESET;
            nop_q  <= lsd_pkg::COUNT_RESET;
            rd_q   <= 32'h0;
        end else begin
            ctrl_q <= ctrl_d;
            nsp_q  <= nsp_d;
            nop_q  <= nop_d;
            rd_q   <= rd_d;
        end
    end

    assign reg_rdata_out = rd_q;

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    sequence s_byte_load;
        go && ok_x && !d_in && size == lsd_pkg::LSD_SIZE_BYTE && !sign;
    endsequence

    a_uncond_issue: assert property (
        instr_valid_in && uncond && go |=> mem_x_req_out)
        else $error("unconditional access not issued");
    a_pre_addr: assert property (
        go && ok_x && !u_in |=>
        mem_x_addr_out == $past(index_value_in) + $past(imm_ext))
        else $error("pre-modify address wrong");
    a_post_update: assert property (
        go && u_in && ok_x |=> index_we_out
        && index_wdata_out == mem_x_addr_out + $past(imm_ext))
        else $error("post-modify writeback wrong");
    a_pre_no_update: assert property (
        instr_valid_in && !u_in |=> !index_we_out)
        else $error("pre-modify updated index");
    a_false_cond: assert property (
        instr_valid_in && !uncond && !cond_true_x_in && !cond_true_y_in
        |=> !mem_x_req_out && !mem_y_req_out && !index_we_out)
        else $error("false condition still acted");
    a_single_no_y: assert property (
        !ctrl_q[lsd_pkg::CTRL_SIMD_BIT] |=> !mem_y_req_out)
        else $error("secondary request outside dual mode");
    a_y_offset: assert property (
        go && ok_x && ok_y |=>
        mem_y_addr_out - mem_x_addr_out == $past(k))
        else $error("secondary offset wrong");
    a_space_fault: assert property (
        fault_space |=> illegal_space_out && !mem_x_req_out
        && !mem_y_req_out)
        else $error("sub-word outside byte space not faulted");
    a_store_mask: assert property (
        mem_x_req_out && mem_write_out
        && mem_size_out == lsd_pkg::LSD_SIZE_BYTE
        |-> mem_x_wdata_out[31:8] == 24'h0)
        else $error("byte store carries high bits");
    a_byte_zext: assert property (
        s_byte_load |-> ##3 rf_write_x_en_out
        && rf_write_x_data_out[31:8] == 24'h0)
        else $error("byte load not zero-extended");
    a_store_sign: assert property (
        instr_valid_in && form_visa_in && d_in && !w_in && x_in
        |=> illegal_op_out && !mem_x_req_out)
        else $error("sign option accepted on store");
endmodule // lsd_decode

// *** rtl/lsd_load_extend.sv ***
`timescale 1ns/1ps
module lsd_load_extend (
    // Raw memory word, sub-word in the low bits
    input  wire logic [31:0]          raw_in,
    input  wire lsd_pkg::lsd_size_e   size_in,
    input  wire logic                 sign_in,
    // Extended word
    output logic [31:0]               data_out
);
    always_comb begin
        data_out = raw_in;
        if (size_in == lsd_pkg::LSD_SIZE_BYTE) begin
            data_out = {{24{sign_in & raw_in[7]}},
                        raw_in[7:0]};
        end else if (size_in == lsd_pkg::LSD_SIZE_SHORT) begin
            data_out = {{16{sign_in & raw_in[15]}},
                        raw_in[15:0]};
        end
    end
endmodule // lsd_load_extend

// *** rtl/lsd_pkg.sv ***
package lsd_pkg;

    // Sub-word size codes carried to the memory port
    typedef enum logic [1:0] {
        LSD_SIZE_WORD  = 2'b00,
        LSD_SIZE_BYTE  = 2'b01,
        LSD_SIZE_SHORT = 2'b10
    } lsd_size_e;

    localparam logic [4:0]  COND_ALWAYS   = 5'h1F;
    localparam int          IMM_W         = 6;
    localparam int          DATA_W        = 32;
    localparam logic [2:0]  LXW_NORMAL    = 3'h7;

    // Secondary element address offsets
    localparam logic [31:0] K_BCAST       = 32'h0;
    localparam logic [31:0] K_NORMAL      = 32'h1;
    localparam logic [31:0] K_SHORT       = 32'h2;
    localparam logic [31:0] K_BYTE        = 32'h4;

    // Index registers that honour the broadcast-read bits
    localparam logic [3:0]  BCAST_IDX_DAG1 = 4'h1;
    localparam logic [3:0]  BCAST_IDX_DAG2 = 4'h9;

    // Register port map
    localparam logic [3:0]  CTRL_OFFSET   = 4'h0;
    localparam logic [3:0]  STATUS_OFFSET = 4'h4;
    localparam int          CTRL_SIMD_BIT = 0;
    localparam int          CTRL_BC1_BIT  = 1;
    localparam int          CTRL_BC2_BIT  = 2;
    localparam logic [2:0]  CTRL_RESET    = 3'h0;
    localparam int          STAT_SPACE_LSB = 0;
    localparam int          STAT_OP_LSB    = 8;
    localparam int          STAT_PEND_BIT  = 16;
    localparam logic [7:0]  COUNT_RESET    = 8'h00;

endpackage

// *** rtl/lsd_size_decode.sv ***
`timescale 1ns/1ps
module lsd_size_decode (
    // Encoding
    input  wire logic                 form_visa_in,
    input  wire logic                 store_in,
    input  wire logic                 l_in,
    input  wire logic                 x_in,
    input  wire logic                 w_in,
    // Decoded size
    output lsd_pkg::lsd_size_e        size_out,
    output logic                      sign_out,
    output logic                      legal_out
);
    always_comb begin
        size_out  = lsd_pkg::LSD_SIZE_WORD;
        sign_out  = 1'b0;
        legal_out = 1'b1;
        // The compute form has no size field and is always a full word
        if (form_visa_in) begin
            if ({l_in, x_in, w_in} == lsd_pkg::LXW_NORMAL) begin
                size_out = lsd_pkg::LSD_SIZE_WORD;
            end else if (!w_in) begin
                size_out = l_in ? lsd_pkg::LSD_SIZE_SHORT
                                : lsd_pkg::LSD_SIZE_BYTE;
                sign_out = x_in;
                // Stores take plain byte or short only; sign is loads only
                legal_out = !(store_in && x_in);
            end else begin
                legal_out = 1'b0;
            end
        end
    end
endmodule // lsd_size_decode

// *** tb/lsd_decode_tb_top.sv ***
`timescale 1ns/1ps
module lsd_decode_tb_top;
    localparam logic [31:0] PAT = 32'hC3B4_A5C3;
    localparam logic [31:0] IV  = 32'h0000_0240;
    localparam logic [31:0] RFX = 32'h8765_43A9;
    localparam logic [31:0] RFY = 32'h1234_F6C7;
    localparam logic [4:0]  AL  = lsd_pkg::COND_ALWAYS;
    localparam logic [2:0]  SZ [7] = '{3'h7, 3'h0, 3'h4, 3'h2,
                                       3'h6, 3'h1, 3'h3};
    logic        clk_in, reset_n_in, reg_write_in, reg_read_in, instr_valid_in;
    logic        form_visa_in, g_in, d_in, u_in, l_in, x_in, w_in;
    logic        cond_true_x_in, cond_true_y_in, byte_space_in;
    logic [2:0]  index_num_in;
    logic [3:0]  reg_addr_in, dreg_num_in, index_sel_out, index_wsel_out;
    logic [3:0]  rf_read_sel_out, rf_write_sel_out;
    logic [4:0]  cond_in;
    logic [5:0]  imm_in;
    logic [31:0] reg_wdata_in, reg_rdata_out, index_value_in, index_wdata_out;
    logic [31:0] rf_read_x_in, rf_read_y_in, rf_write_x_data_out;
    logic [31:0] rf_write_y_data_out, mem_x_addr_out, mem_y_addr_out;
    logic [31:0] mem_x_wdata_out, mem_y_wdata_out;
    logic [31:0] mem_x_rdata_in, mem_y_rdata_in;
    logic        index_we_out, rf_write_x_en_out, rf_write_y_en_out;
    logic        mem_x_req_out, mem_y_req_out, mem_write_out, mem_pm_out;
    logic        compute_en_out, illegal_space_out, illegal_op_out;
    lsd_pkg::lsd_size_e mem_size_out;
    logic [2:0]  mode = 3'h0;
    logic [7:0]  nop = 8'h0;
    logic [7:0]  nsp = 8'h0;
    int          errors = 0;
    int          n_tests = 0;

    lsd_decode dut_u (.*);

    lsd_mem_model #(.PAT(PAT)) mem_u (
        .clk_in      (clk_in),
        .req_x_in    (mem_x_req_out),
        .req_y_in    (mem_y_req_out),
        .write_in    (mem_write_out),
        .addr_x_in   (mem_x_addr_out),
        .addr_y_in   (mem_y_addr_out),
        .rdata_x_out (mem_x_rdata_in),
        .rdata_y_out (mem_y_rdata_in)
    );

    ////////////////////////////////////////////////////////////
    task automatic test_done;
        if (errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH at %0t: got %h want %h", $time, s, e);
        end
    endtask

    function automatic logic [31:0] ext(logic [31:0] v, logic [1:0] s,
                                        logic e);
        if (s == 2'h1)
            return {{24{e & v[7]}}, v[7:0]};
        if (s == 2'h2)
            return {{16{e & v[15]}}, v[15:0]};
        return v;
    endfunction

    task automatic reg_wr(input logic [3:0] ad, input logic [31:0] v);
        @(posedge clk_in);
        reg_addr_in  <= ad;
        reg_wdata_in <= v;
        reg_write_in <= 1'h1;
        @(posedge clk_in);
        reg_write_in <= 1'h0;
    endtask

    task automatic reg_rd(input logic [3:0] ad, input logic [31:0] e);
        @(posedge clk_in);
        reg_addr_in <= ad;
        reg_read_in <= 1'h1;
        @(posedge clk_in);
        reg_read_in <= 1'h0;
        #1;
        chk(reg_rdata_out, e);
    endtask

    task automatic set_mode(input logic [2:0] m);
        mode = m;
        reg_wr(4'h0, {29'h0, m});
        reg_rd(4'h0, {29'h0, m});
    endtask

    ////////////////////////////////////////////////////////////
    // gdu = {g, d, u}, c = {cond true x, cond true y, byte space}
    task automatic run(input logic [2:0] gdu, input logic [2:0] ix,
                       input logic [5:0] im, input logic [2:0] lxw,
                       input logic fm, input logic [4:0] cd,
                       input logic [2:0] c);
        logic [31:0] a, k, ms, ni, rx, ry;
        logic [1:0]  sz;
        logic        sg, ok, op, sp, ex, ey, ld;
        sz = (!fm || lxw[0]) ? 2'h0 : (lxw[2] ? 2'h2 : 2'h1);
        sg = fm && !lxw[0] && lxw[1];
        ok = !fm || lxw == 3'h7 || (!lxw[0] && !(gdu[1] && lxw[1]));
        op = !ok;
        sp = ok && sz != 2'h0 && !c[0];
        ex = ok && !sp && (cd == AL || c[2]);
        ey = ok && !sp && (cd == AL || c[1]) && mode[0];
        ni = IV + {{26{im[5]}}, im};
        a  = gdu[0] ? IV : ni;
        k  = (sz == 2'h1) ? 32'h4 : (sz == 2'h2) ? 32'h2 : 32'h1;
        ld = !gdu[1];
        // Broadcast only ever applies to reads through index 1 or 9
        if (ld && ix == 3'h1 && (gdu[2] ? mode[2] : mode[1]))
            k = 32'h0;
        ms = ext(32'hFFFF_FFFF, sz, 1'h0);
        rx = ext(a ^ PAT, sz, sg);
        ry = ext((a + k) ^ PAT, sz, sg);
        nop = nop + {7'h0, op};
        nsp = nsp + {7'h0, sp};
        @(posedge clk_in);
        {g_in, d_in, u_in, index_num_in, imm_in} <= {gdu, ix, im};
        {l_in, x_in, w_in, form_visa_in, cond_in} <= {lxw, fm, cd};
        {cond_true_x_in, cond_true_y_in, byte_space_in} <= c;
        dreg_num_in    <= {1'h1, ix};
        instr_valid_in <= 1'h1;
        #1;
        chk(index_sel_out, {gdu[2], ix});
        chk(rf_read_sel_out, {1'h1, ix});
        @(posedge clk_in);
        instr_valid_in <= 1'h0;
        #1;
        chk(mem_x_req_out, ex);
        chk(mem_y_req_out, ey);
        chk({illegal_op_out, illegal_space_out}, {op, sp});
        chk(compute_en_out, !fm && (ex || ey));
        chk(index_we_out, gdu[0] && (ex || ey));
        if (gdu[0] && (ex || ey)) begin
            chk(index_wsel_out, {gdu[2], ix});
            chk(index_wdata_out, ni);
        end
        if (ex)
            chk(mem_x_addr_out, a);
        if (ey)
            chk(mem_y_addr_out, a + k);
        if (ex || ey)
            chk({mem_pm_out, mem_write_out, mem_size_out},
                {gdu[2:1], sz});
        if (!ld && ex)
            chk(mem_x_wdata_out, RFX & ms);
        if (!ld && ey)
            chk(mem_y_wdata_out, RFY & ms);
        @(posedge clk_in);
        @(posedge clk_in);
        #1;
        chk(rf_write_x_en_out, ld && ex);
        chk(rf_write_y_en_out, ld && ey);
        if (ld && ex)
            chk(rf_write_x_data_out, rx);
        if (ld && ey)
            chk(rf_write_y_data_out, ry);
        if (ld && ex)
            chk(rf_write_sel_out, {1'h1, ix});
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        clk_in = 1'h0;
        forever #2.5 clk_in = ~clk_in;
    end

    initial begin
        repeat (3000) @(posedge clk_in);
        errors++;
        test_done;
    end

    initial begin
        logic [2:0] gdu;
        {reg_addr_in, reg_wdata_in, reg_write_in, reg_read_in} = '0;
        {instr_valid_in, form_visa_in, cond_in, g_in, d_in, u_in} = '0;
        {index_num_in, dreg_num_in, imm_in, l_in, x_in, w_in} = '0;
        {cond_true_x_in, cond_true_y_in, byte_space_in} = '0;
        index_value_in = IV;
        rf_read_x_in   = RFX;
        rf_read_y_in   = RFY;
        reset_n_in     = 1'h0;
        repeat (20) @(posedge clk_in);
        reset_n_in <= 1'h1;
        reg_rd(4'h0, 32'h0);
        reg_rd(4'hC, 32'h0);
        for (int i = 0; i < 8; i++)
            run(i[2:0], 3'h3, 6'h3D, 3'h7, 1'h1, AL, 3'h1);
        run(3'h1, 3'h2, 6'h05, 3'h0, 1'h0, AL, 3'h0);
        run(3'h3, 3'h2, 6'h05, 3'h7, 1'h1, 5'h04, 3'h3);
        run(3'h5, 3'h2, 6'h3D, 3'h7, 1'h1, 5'h04, 3'h5);
        set_mode(3'h1);
        for (int n = 0; n < 14; n++) begin
            gdu = (n < 7) ? 3'h1 : 3'h3;
            run(gdu, 3'h2, 6'h3D, SZ[n % 7], 1'h1, AL, 3'h1);
        end
        run(3'h5, 3'h2, 6'h05, 3'h4, 1'h1, AL, 3'h0);
        run(3'h1, 3'h2, 6'h05, 3'h7, 1'h1, 5'h04, 3'h3);
        run(3'h3, 3'h2, 6'h05, 3'h0, 1'h1, 5'h04, 3'h5);
        run(3'h1, 3'h2, 6'h05, 3'h7, 1'h1, 5'h04, 3'h1);
        set_mode(3'h3);
        run(3'h0, 3'h1, 6'h05, 3'h7, 1'h1, AL, 3'h1);
        run(3'h2, 3'h1, 6'h05, 3'h7, 1'h1, AL, 3'h1);
        run(3'h4, 3'h1, 6'h05, 3'h4, 1'h1, AL, 3'h1);
        set_mode(3'h5);
        run(3'h5, 3'h1, 6'h3D, 3'h0, 1'h1, AL, 3'h1);
        run(3'h1, 3'h1, 6'h3D, 3'h7, 1'h1, AL, 3'h1);
        // Status is read-only, so this write must leave the counts alone
        reg_wr(4'h4, 32'hFFFF_FFFF);
        reg_rd(4'h4, {16'h0, nop, nsp});
        test_done;
    end
endmodule // lsd_decode_tb_top

// *** tb/lsd_mem_model.sv ***
`timescale 1ns/1ps
module lsd_mem_model #(
    parameter logic [31:0] PAT = 32'hC3B4_A5C3
) (
    // Clock
    input  wire logic        clk_in,
    // Requests
    input  wire logic        req_x_in,
    input  wire logic        req_y_in,
    input  wire logic        write_in,
    input  wire logic [31:0] addr_x_in,
    input  wire logic [31:0] addr_y_in,
    // Read data
    output logic      [31:0] rdata_x_out,
    output logic      [31:0] rdata_y_out
);
    // Idle data flips every cycle so a late sample cannot match
    initial begin
        rdata_x_out = 32'h0;
        rdata_y_out = 32'h0;
    end
    always @(posedge clk_in) begin
        if (req_x_in && !write_in)
            rdata_x_out <= addr_x_in ^ PAT;
        else
            rdata_x_out <= ~rdata_x_out;
        if (req_y_in && !write_in)
            rdata_y_out <= addr_y_in ^ PAT;
        else
            rdata_y_out <= ~rdata_y_out;
    end
endmodule // lsd_mem_model
